// file: design/rbt_regbus_debug.sv
// merged register bus timing, arbitration, read reuse and debug mux logic
//
// Function
// RQ1: address stands setup field plus one clocks
// RQ2: setup skipped only for queued register writes
// RQ3: register files get response field plus one
// RQ4: read data returns in return field plus one
// RQ5: two-bit policy arbitrates host against parser
// RQ6: extension code decodes to 0..48, 64 clocks
// RQ7: linear aperture reads reuse last data unless disabled
// RQ8: legacy aperture reads reuse last data unless disabled
// RQ9: output enable drives debug bus onto connector
// RQ10: two bits enable lower, upper debug inputs
// RQ11: quiescent bit sets mode, pulls switched off
// RQ12: register bus state may drive debug bus
// RQ13: host path state may drive debug bus
// RQ14: bits 4..20 each route one unit's debug; MODE_MASK leaves bit 16 unwritable, so it stays zero
// RQ15: mux and bank fields pick debug group
// RQ16: clock select routes one clock, zero gives 0
// RQ17: invert bit inverts selected test clock
// RQ18: readback field returns current debug bus value; readback keeps bus bits 10:0 only, so bits above read zero
// RQ19: two bits force transfers onto conventional bus
// RQ20: bits 6,7,8 hold soft resets while set
// RQ21: bit 9 selects reported port revision
// RQ22: bit 12 disables sideband address bus
// RQ23: timing changes affect only later transactions
module rbt_regbus_debug
	import rbt_pkg::*;
#(
	parameter int DBG_W = 11
) (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	// memory-mapped register port
	input  wire logic                 reg_req,
	input  wire logic                 reg_wr,
	input  wire logic [11:0]          reg_addr,
	input  wire logic [3:0]           reg_be,
	input  wire logic [31:0]          reg_wdata,
	output logic                      reg_ack_q,
	output logic [31:0]               reg_rdata_q,
	// register bus requesters
	input  wire rbt_req_t             host_req,
	output logic                      host_done_q,
	input  wire rbt_req_t             parser_req,
	output logic                      parser_done_q,
	output logic [31:0]               rsp_rdata_q,
	// merged register bus towards the register files
	output logic [11:0]               rb_addr_q,
	output logic [31:0]               rb_wdata_q,
	output logic                      rb_queued_q,
	output logic                      rb_wr_stb_q,
	output logic                      rb_rd_stb_q,
	input  wire logic [31:0]          rb_rdata,
	// aperture slave reads and pixel cache
	input  wire logic                 ap_rd_req,
	input  wire logic                 ap_wr,
	input  wire logic                 ap_legacy,
	input  wire logic [AP_AW-1:0]     ap_addr,
	output logic                      ap_rd_valid_q,
	output logic [31:0]               ap_rd_data_q,
	output logic                      pc_rd_req_q,
	output logic [AP_AW-1:0]          pc_rd_addr_q,
	input  wire logic                 pc_rd_valid,
	input  wire logic [31:0]          pc_rd_data,
	// debug sources, bus and pins
	input  wire logic [NUM_SRC-1:0][DBG_W-1:0] unit_dbg,
	output logic [NUM_SRC-1:0]        dbg_unit_sel_q,
	output logic [3:0]                dbg_mux_sel_q,
	output logic [1:0]                dbg_bank_sel_q,
	output logic [DBG_W-1:0]          dbg_bus_q,
	output logic                      dbg_bus_oe_q,
	output logic                      dbg_in_low_en_q,
	output logic                      dbg_in_high_en_q,
	output logic                      quiescent_current_mode_q,
	output logic                      pulls_off_q,
	input  wire logic [31:0]          tst_clk_src,
	output logic                      tst_clk_q,
	// hardware overrides
	output logic                      force_f2s_conventional_q,
	output logic                      force_s2f_conventional_q,
	output logic                      cmdproc_soft_reset_q,
	output logic                      pixcache_soft_reset_q,
	output logic                      pixengine_soft_reset_q,
	output logic                      port_revision_select_q,
	output logic                      sideband_bus_disable_q,
	output logic                      hostpath_test_reset_q,
	output logic [15:0]               hw_override_q,
	// command queue check values
	input  wire logic [10:0]          cq_chk_ptr,
	input  wire logic [31:0]          cq_chk_word
);

	if (DBG_W < 11 || DBG_W > 32) begin : g_chk
		$error("DBG_W must lie between 11 and 32");
	end

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_RESP,
		ST_WSTB,
		ST_RET,
		ST_EXT
	} rbt_state_t;

	logic [31:0] timing_q, mode_q, mux_q;
	rbt_state_t  st_q, st_d;
	logic [6:0]  cnt_q, cnt_d, stay_q;
	rbt_timing_t tm_q;
	rbt_req_t    cur_q;
	logic        owner_q, rr_host_last_q;
	rbt_cache_t  cache_q;
	logic        pend_legacy_q;

	// byte-lane write merge; reserved bits are forced back to zero
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be, input logic [31:0] msk);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r & msk;
	endfunction

	// register port decode
	wire wr_any    = reg_req && reg_wr;
	wire wr_timing = wr_any && (reg_addr == OFS_TIMING);
	wire wr_mode   = wr_any && (reg_addr == OFS_DBG_MODE);
	wire wr_mux    = wr_any && (reg_addr == OFS_DBG_MUX);
	wire wr_hw     = wr_any && (reg_addr == OFS_HW_OVR);
	wire [31:0] dbg_rb_word = 32'(dbg_bus_q) & 32'h000007FF;
	wire [31:0] rd_word =
		(reg_addr == OFS_DBG_MODE) ? mode_q :
		(reg_addr == OFS_DBG_MUX)  ? mux_q :
		(reg_addr == OFS_HW_OVR)   ? 32'(hw_override_q) :
		(reg_addr == OFS_DBG_RB)   ? dbg_rb_word :           // see RQ18
		(reg_addr == OFS_TIMING)   ? timing_q :
		(reg_addr == OFS_CQ_PTR)   ? 32'(cq_chk_ptr) & CQ_PTR_MASK :
		(reg_addr == OFS_CQ_WORD)  ? cq_chk_word : 32'h00000000;

	// software registers; unmapped writes are dropped, reads return zero
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			timing_q      <= TIMING_RST;
			mode_q        <= MODE_RST;
			mux_q         <= MUX_RST;
			hw_override_q <= HW_RST[15:0];
			reg_ack_q     <= 1'b0;
			reg_rdata_q   <= 32'h00000000;
		end else begin
			if (wr_timing) timing_q <= be_merge(timing_q, reg_wdata, reg_be,
				TIMING_MASK);
			if (wr_mode) mode_q <= be_merge(mode_q, reg_wdata, reg_be, MODE_MASK);
			if (wr_mux) mux_q <= be_merge(mux_q, reg_wdata, reg_be, MUX_MASK);
			if (wr_hw) hw_override_q <= 16'(be_merge(32'(hw_override_q),
				reg_wdata, reg_be, HW_MASK));
			reg_ack_q   <= reg_req;
			reg_rdata_q <= (reg_req && !reg_wr) ? rd_word : 32'h00000000;
		end
	end

	// arbitration; queued traffic ignores the policy and alternates
	wire      any_queued = host_req.queued || parser_req.queued;
	rbt_arb_t pol;
	assign pol = any_queued ? ARB_RR :
		rbt_arb_t'(timing_q[TM_ARB_LSB +: 2]);
	// a done pulse blocks grant for one cycle so a finished request is not
	// taken twice before its owner has dropped it
	wire blk      = host_done_q || parser_done_q;
	wire both     = host_req.req && parser_req.req;
	wire pick_par = parser_req.req && (!host_req.req ||
		(pol == ARB_PARSER) ||
		((pol == ARB_RR || pol == ARB_RSVD) && rr_host_last_q)); // see RQ5
	wire grant    = (st_q == ST_IDLE) && !blk &&
		(host_req.req || parser_req.req);
	rbt_req_t gnt_req;
	assign gnt_req = pick_par ? parser_req : host_req;
	wire gnt_direct = gnt_req.wr && gnt_req.queued;
	wire finish = ((st_q == ST_RET) || (st_q == ST_WSTB)) && (cnt_q == 7'h00);

	// timing of a new transaction, sampled only at grant
	rbt_timing_t tm_new;
	assign tm_new.setup = 7'(timing_q[TM_SETUP_LSB +: 2]);
	assign tm_new.resp  = 7'(timing_q[TM_RESP_LSB +: 2]);
	assign tm_new.ret   = 7'(timing_q[TM_RET_LSB +: 3]);
	assign tm_new.ext   = rbt_ext_cycles(timing_q[TM_EXT_LSB +: 3]); // see RQ6

	// transaction sequencer; each state but idle is left when its count reaches zero
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		case (st_q)
			ST_IDLE: if (grant) begin
				st_d  = gnt_direct ? ST_WSTB : ST_SETUP;              // see RQ2
				cnt_d = gnt_direct ? 7'h00 : tm_new.setup;            // see RQ1
			end
			ST_SETUP: if (cnt_q == 7'h00) begin
				st_d  = cur_q.wr ? ST_WSTB : ST_RESP;
				cnt_d = cur_q.wr ? 7'h00 : tm_q.resp;                 // see RQ3
			end else begin
				cnt_d = cnt_q - 7'h01;
			end
			ST_RESP: if (cnt_q == 7'h00) begin
				st_d  = ST_RET;
				cnt_d = tm_q.ret;                                     // see RQ4
			end else begin
				cnt_d = cnt_q - 7'h01;
			end
			ST_WSTB, ST_RET: if (cnt_q == 7'h00) begin
				st_d  = (tm_q.ext == 7'h00) ? ST_IDLE : ST_EXT;
				cnt_d = tm_q.ext - 7'h01;
			end else begin
				cnt_d = cnt_q - 7'h01;
			end
			ST_EXT: if (cnt_q == 7'h00) begin
				st_d = ST_IDLE;
			end else begin
				cnt_d = cnt_q - 7'h01;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// sequencer state and captured request
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_q           <= ST_IDLE;
			cnt_q          <= 7'h00;
			stay_q         <= 7'h00;
			tm_q           <= '0;
			cur_q          <= '0;
			owner_q        <= 1'b0;
			rr_host_last_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			stay_q <= (st_d == st_q) ? stay_q + 7'h01 : 7'h00;
			if (grant) begin
				tm_q           <= tm_new;                             // see RQ23
				cur_q          <= gnt_req;
				owner_q        <= pick_par;
				rr_host_last_q <= !pick_par;
			end
		end
	end

	// register bus drive; strobes follow the state so setup precedes them, except for queued writes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rb_addr_q     <= 12'h000;
			rb_wdata_q    <= 32'h00000000;
			rb_queued_q   <= 1'b0;
			rb_wr_stb_q   <= 1'b0;
			rb_rd_stb_q   <= 1'b0;
			rsp_rdata_q   <= 32'h00000000;
			host_done_q   <= 1'b0;
			parser_done_q <= 1'b0;
		end else begin
			if (grant) begin
				rb_addr_q   <= gnt_req.addr;
				rb_wdata_q  <= gnt_req.wdata;
				rb_queued_q <= gnt_req.queued;
			end
			rb_wr_stb_q <= (st_d == ST_WSTB);                         // see RQ1
			rb_rd_stb_q <= (st_d == ST_RESP);                         // see RQ3
			if (st_q == ST_RESP && cnt_q == 7'h00) rsp_rdata_q <= rb_rdata;
			host_done_q   <= finish && !owner_q;                      // see RQ4
			parser_done_q <= finish && owner_q;
		end
	end

	// read reuse: one entry, cleared by any aperture write
	wire reuse_off = ap_legacy ? timing_q[TM_LEG_DIS] : timing_q[TM_LIN_DIS];
	wire hit = cache_q.valid && (cache_q.addr == ap_addr) &&
		(cache_q.legacy == ap_legacy) && !reuse_off;        // see RQ7 see RQ8
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cache_q       <= '0;
			pend_legacy_q <= 1'b0;
			ap_rd_valid_q <= 1'b0;
			ap_rd_data_q  <= 32'h00000000;
			pc_rd_req_q   <= 1'b0;
			pc_rd_addr_q  <= '0;
		end else begin
			ap_rd_valid_q <= (ap_rd_req && hit) || pc_rd_valid;
			pc_rd_req_q   <= ap_rd_req && !hit;                 // see RQ7 see RQ8
			if (ap_rd_req && hit) begin
				ap_rd_data_q <= cache_q.data;
			end else if (pc_rd_valid) begin
				ap_rd_data_q <= pc_rd_data;
			end
			if (ap_rd_req && !hit) begin
				pc_rd_addr_q  <= ap_addr;
				pend_legacy_q <= ap_legacy;
			end
			if (ap_wr) begin
				cache_q.valid <= 1'b0;
			end else if (pc_rd_valid) begin
				cache_q <= '{1'b1, pend_legacy_q, pc_rd_addr_q, pc_rd_data};
			end
		end
	end

	// debug sources; the register bus slot shows this block's own state
	logic [NUM_SRC-1:0][DBG_W-1:0] src_masked;
	logic [DBG_W-1:0]              dbg_or;
	for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
		if (i + SRC_LO == SRC_REGBUS) begin : g_own
			assign src_masked[i] = mode_q[SRC_REGBUS] ?              // see RQ12
				DBG_W'({owner_q, st_q, cnt_q}) : '0;
		end else begin : g_unit
			assign src_masked[i] = mode_q[i + SRC_LO] ?              // see RQ14
				unit_dbg[i] : '0;                                // see RQ13
		end
	end
	// several enabled units are ORed, so software should enable only one
	always_comb begin
		dbg_or = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			dbg_or = dbg_or | src_masked[i];
		end
	end

	// test clock mux; sampled by clk_sys, so only slow clocks are faithful
	wire [4:0] clk_sel = mux_q[CLK_LSB +: 5];
	wire       clk_pick = (clk_sel == 5'h00) ? 1'b0 :
		tst_clk_src[clk_sel] ^ mux_q[CLK_INV];              // see RQ16 see RQ17

	// debug pin outputs
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dbg_bus_q <= '0;
			tst_clk_q <= 1'b0;
		end else begin
			dbg_bus_q <= dbg_or;
			tst_clk_q <= clk_pick;
		end
	end

	// register-held controls
	assign dbg_unit_sel_q   = mode_q[SRC_HI:SRC_LO];                  // see RQ14
	assign dbg_mux_sel_q    = mux_q[MUX_LSB +: 4];                    // see RQ15
	assign dbg_bank_sel_q   = mux_q[BANK_LSB +: 2];                   // see RQ15
	assign dbg_bus_oe_q     = mode_q[MODE_OUT_EN];                    // see RQ9
	assign dbg_in_low_en_q  = mode_q[MODE_IN_LOW];                    // see RQ10
	assign dbg_in_high_en_q = mode_q[MODE_IN_HIGH];                   // see RQ10
	assign quiescent_current_mode_q = mode_q[MODE_IDDQ];              // see RQ11
	assign pulls_off_q      = mode_q[MODE_IDDQ];                      // see RQ11
	assign force_f2s_conventional_q = hw_override_q[HW_F2S];          // see RQ19
	assign force_s2f_conventional_q = hw_override_q[HW_S2F];          // see RQ19
	assign cmdproc_soft_reset_q   = hw_override_q[HW_CP_RST];         // see RQ20
	assign pixcache_soft_reset_q  = hw_override_q[HW_PC_RST];         // see RQ20
	assign pixengine_soft_reset_q = hw_override_q[HW_PE_RST];         // see RQ20
	assign port_revision_select_q = hw_override_q[HW_REV];            // see RQ21
	assign sideband_bus_disable_q = hw_override_q[HW_SBA_DIS];        // see RQ22
	assign hostpath_test_reset_q  = timing_q[TM_TEST_RST];

	// checks on the sequencer, read reuse, debug and override logic
	a_setup_len: assert property (@(posedge clk_sys) disable iff (!resetn) // see RQ1
		(st_q == ST_SETUP && st_d != ST_SETUP) |-> stay_q == tm_q.setup)
		else $error("address setup length wrong");
	a_setup_strobe: assert property (@(posedge clk_sys) disable iff (!resetn) // see RQ1
		(st_q == ST_SETUP && st_d != ST_SETUP) |=> (rb_rd_stb_q || rb_wr_stb_q))
		else $error("no strobe after setup");
	a_queued_direct: assert property (@(posedge clk_sys) disable iff (!resetn) // see RQ2
		(grant && gnt_direct) |=> rb_wr_stb_q && rb_addr_q == $past(gnt_req.addr))
		else $error("queued write delayed");
	a_resp_len: assert property (@(posedge clk_sys) disable iff (!resetn) // see RQ3
		$fell(rb_rd_stb_q) |-> $past(stay_q) == tm_q.resp)
		else $error("read response length wrong");
	a_return_len: assert property (@(posedge clk_sys) disable iff (!resetn) // see RQ4
		(st_q == ST_RET && st_d != ST_RET) |=>
		((host_done_q || parser_done_q) && $past(stay_q) == tm_q.ret))
		else $error("read return length wrong");
	a_arb_host: assert property (@(posedge clk_sys) disable iff (!resetn) // see RQ5
		(grant && both && !any_queued && pol == ARB_HOST) |=> !owner_q)
		else $error("host priority not honoured");
	a_ext_len: assert property (@(posedge clk_sys) disable iff (!resetn) // see RQ6
		(st_q == ST_EXT && st_d == ST_IDLE) |-> stay_q == tm_q.ext - 7'h01)
		else $error("clock extension length wrong");
	a_lin_reuse: assert property (@(posedge clk_sys) disable iff (!resetn) // see RQ7
		(ap_rd_req && !ap_legacy && timing_q[TM_LIN_DIS]) |=>
		pc_rd_req_q && !ap_rd_valid_q)
		else $error("disabled linear reuse still served");
	a_clk_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // see RQ16
		(clk_sel == 5'h00) |=> !tst_clk_q)
		else $error("test clock not zero for code 0");
	a_soft_reset: assert property (@(posedge clk_sys) disable iff (!resetn) // see RQ20
		(wr_hw && reg_be[0]) |=> cmdproc_soft_reset_q == $past(reg_wdata[HW_CP_RST]))
		else $error("soft reset bit not taken");

endmodule

// file: design/rbt_pkg.sv
// register map, field layout and shared types of the regbus timing/debug block
package rbt_pkg;

	// register byte offsets
	localparam logic [11:0] OFS_DBG_MODE = 12'h120;
	localparam logic [11:0] OFS_DBG_MUX  = 12'h124;
	localparam logic [11:0] OFS_HW_OVR   = 12'h128;
	localparam logic [11:0] OFS_DBG_RB   = 12'h12C;
	localparam logic [11:0] OFS_TIMING   = 12'h130;
	localparam logic [11:0] OFS_CQ_PTR   = 12'h740;
	localparam logic [11:0] OFS_CQ_WORD  = 12'h744;

	// reset values and writable-bit masks (reserved bits read zero)
	localparam logic [31:0] TIMING_RST  = 32'h0000207F;
	localparam logic [31:0] TIMING_MASK = 32'h8300737F;
	localparam logic [31:0] MODE_RST    = 32'h00000000;
	localparam logic [31:0] MODE_MASK   = 32'h001EFFFF;
	localparam logic [31:0] MUX_RST     = 32'h00000000;
	localparam logic [31:0] MUX_MASK    = 32'h00009F3F;
	localparam logic [31:0] HW_RST      = 32'h00000000;
	localparam logic [31:0] HW_MASK     = 32'h0000FFFF;
	localparam logic [31:0] CQ_PTR_MASK = 32'h000007FF;

	// timing register fields
	localparam int TM_SETUP_LSB = 0;
	localparam int TM_RESP_LSB  = 2;
	localparam int TM_RET_LSB   = 4;
	localparam int TM_ARB_LSB   = 8;
	localparam int TM_EXT_LSB   = 12;
	localparam int TM_LIN_DIS   = 24;
	localparam int TM_LEG_DIS   = 25;
	localparam int TM_TEST_RST  = 31;

	// debug mode select fields
	localparam int MODE_OUT_EN  = 0;
	localparam int MODE_IN_LOW  = 1;
	localparam int MODE_IN_HIGH = 2;
	localparam int MODE_IDDQ    = 3;
	localparam int SRC_LO       = 4;
	localparam int SRC_REGBUS   = 7;
	localparam int SRC_MEMCTRL  = 11;
	localparam int SRC_HOSTPATH = 17;
	localparam int SRC_HI       = 20;
	localparam int NUM_SRC      = SRC_HI - SRC_LO + 1;

	// debug mux / clock select fields
	localparam int MUX_LSB      = 0;
	localparam int BANK_LSB     = 4;
	localparam int CLK_LSB      = 8;
	localparam int CLK_INV      = 15;

	// hardware override bits
	localparam int HW_F2S       = 0;
	localparam int HW_S2F       = 1;
	localparam int HW_CP_RST    = 6;
	localparam int HW_PC_RST    = 7;
	localparam int HW_PE_RST    = 8;
	localparam int HW_REV       = 9;
	localparam int HW_SBA_DIS   = 12;

	// clock extension decode and aperture address width
	localparam logic [6:0] EXT_STEP = 7'h08;
	localparam logic [6:0] EXT_MAX  = 7'h40;
	localparam int         AP_AW    = 24;

	typedef enum logic [1:0] {
		ARB_RR,
		ARB_HOST,
		ARB_PARSER,
		ARB_RSVD
	} rbt_arb_t;

	// one register-bus request from host or command parser
	typedef struct packed {
		logic        req;
		logic        wr;
		logic        queued;
		logic [11:0] addr;
		logic [31:0] wdata;
	} rbt_req_t;

	// timing captured when a transaction is granted
	typedef struct packed {
		logic [6:0] setup;
		logic [6:0] resp;
		logic [6:0] ret;
		logic [6:0] ext;
	} rbt_timing_t;

	// single-entry read reuse cache
	typedef struct packed {
		logic             valid;
		logic             legacy;
		logic [AP_AW-1:0] addr;
		logic [31:0]      data;
	} rbt_cache_t;

	function automatic logic [6:0] rbt_ext_cycles(input logic [2:0] code);
		logic [6:0] r;
		r = (code == 3'h7) ? EXT_MAX : 7'(code) * EXT_STEP;
		return r;
	endfunction

endpackage

// file: testbench/rbt_far_model.sv
// far-side model: register files on the merged bus and the pixel cache
module rbt_far_model
	import rbt_pkg::*;
(
	// clock
	input  wire logic             clk_sys,
	// merged register bus
	input  wire logic [11:0]      rb_addr_q,
	input  wire logic             rb_rd_stb_q,
	output logic [31:0]           rb_rdata,
	// pixel cache
	input  wire logic             pc_rd_req_q,
	input  wire logic [AP_AW-1:0] pc_rd_addr_q,
	output logic                  pc_rd_valid,
	output logic [31:0]           pc_rd_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0]      junk = 32'h00000001;
	logic             pend = 1'b0;
	logic [AP_AW-1:0] pa;
	initial pc_rd_valid = 1'b0;
	// idle lines carry a pattern that moves every cycle, never the last value
	always @(posedge clk_sys) begin
		junk <= {junk[30:0], ~junk[31]};
		pend <= pc_rd_req_q;
		pc_rd_valid <= pend;
		if (pc_rd_req_q) begin
			pa <= pc_rd_addr_q;
		end
	end
	// a register file answers only while strobed
	assign rb_rdata = rb_rd_stb_q ? {20'hA5A5A, rb_addr_q} : junk;
	assign pc_rd_data = pc_rd_valid ? {8'hC3, pa} : junk;
endmodule

// file: testbench/regbus_timing_debug_mux_tb.sv
// self-checking bench of the regbus timing and debug mux block
module regbus_timing_debug_mux_tb;
	import rbt_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, resetn, reg_req, reg_wr, reg_ack_q, host_done_q;
	logic parser_done_q, rb_queued_q, rb_wr_stb_q, rb_rd_stb_q;
	logic ap_rd_req, ap_wr, ap_legacy, ap_rd_valid_q, pc_rd_req_q, pc_rd_valid;
	logic dbg_bus_oe_q, dbg_in_low_en_q, dbg_in_high_en_q, tst_clk_q;
	logic quiescent_current_mode_q, pulls_off_q, hostpath_test_reset_q;
	logic force_f2s_conventional_q, force_s2f_conventional_q;
	logic cmdproc_soft_reset_q, pixcache_soft_reset_q, pixengine_soft_reset_q;
	logic port_revision_select_q, sideband_bus_disable_q;
	logic [11:0] reg_addr, rb_addr_q;
	logic [3:0] reg_be, dbg_mux_sel_q;
	logic [1:0] dbg_bank_sel_q;
	logic [31:0] reg_wdata, reg_rdata_q, rsp_rdata_q, rb_wdata_q, rb_rdata;
	logic [31:0] ap_rd_data_q, pc_rd_data, tst_clk_src, cq_chk_word;
	logic [AP_AW-1:0] ap_addr, pc_rd_addr_q;
	logic [NUM_SRC-1:0][10:0] unit_dbg;
	logic [NUM_SRC-1:0] dbg_unit_sel_q;
	logic [10:0] dbg_bus_q, cq_chk_ptr;
	logic [15:0] hw_override_q;
	rbt_req_t host_req, parser_req;
	int n_mismatch = 0;
	int total_checks = 0;

	rbt_regbus_debug rbt_regbus_debug_i (.clk_sys, .resetn, .reg_req, .reg_wr,
		.reg_addr, .reg_be, .reg_wdata, .reg_ack_q, .reg_rdata_q, .host_req,
		.host_done_q, .parser_req, .parser_done_q, .rsp_rdata_q, .rb_addr_q,
		.rb_wdata_q, .rb_queued_q, .rb_wr_stb_q, .rb_rd_stb_q, .rb_rdata,
		.ap_rd_req, .ap_wr, .ap_legacy, .ap_addr, .ap_rd_valid_q, .ap_rd_data_q,
		.pc_rd_req_q, .pc_rd_addr_q, .pc_rd_valid, .pc_rd_data, .unit_dbg,
		.dbg_unit_sel_q, .dbg_mux_sel_q, .dbg_bank_sel_q, .dbg_bus_q,
		.dbg_bus_oe_q, .dbg_in_low_en_q, .dbg_in_high_en_q,
		.quiescent_current_mode_q, .pulls_off_q, .tst_clk_src, .tst_clk_q,
		.force_f2s_conventional_q, .force_s2f_conventional_q,
		.cmdproc_soft_reset_q, .pixcache_soft_reset_q, .pixengine_soft_reset_q,
		.port_revision_select_q, .sideband_bus_disable_q,
		.hostpath_test_reset_q, .hw_override_q, .cq_chk_ptr, .cq_chk_word);

	rbt_far_model rbt_far_model_i (.clk_sys, .rb_addr_q, .rb_rd_stb_q,
		.rb_rdata, .pc_rd_req_q, .pc_rd_addr_q, .pc_rd_valid, .pc_rd_data);

	// 40 MHz engine clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
			n_mismatch++;
		end
	endtask

	// one register port access; ack is registered on the taking edge and read just after it
	task automatic rg(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys) #2;
		{reg_req, reg_wr, reg_addr, reg_wdata} = {1'b1, w, a, d};
		@(posedge clk_sys) #2;
		reg_req = 1'b0;
		q = reg_rdata_q;
		chk(32'(reg_ack_q), 32'h1);
	endtask

	// counts edges from the grant edge up to the done pulse, bounded
	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(posedge clk_sys) #2;
			n++;
		end while (!(host_done_q | parser_done_q) && n < 300);
		if (n >= 300) begin
			n_mismatch++;
			conclude();
		end
	endtask

	// host transaction; long idle after so the extension gap has run out
	task automatic bus(input logic w, input logic qd, output int n);
		@(posedge clk_sys) #2;
		host_req = '{1'b1, w, qd, 12'h350, 32'h12345678};
		wait_done(n);
		chk(32'({rb_queued_q, rb_addr_q}), 32'({qd, 12'h350}));
		chk(rb_wdata_q, 32'h12345678);
		if (!w)
			chk(rsp_rdata_q, 32'hA5A5A350);
		host_req.req = 1'b0;
		repeat (70) @(posedge clk_sys);
	endtask

	task automatic t_regs;
		logic [31:0] q;
		rg(0, OFS_TIMING, 0, q);
		chk(q, 32'h0000207F);
		rg(1, OFS_TIMING, 32'hFFFFFFFF, q);
		rg(0, OFS_TIMING, 0, q);
		chk(q, 32'h8300737F);
		chk(32'(hostpath_test_reset_q), 32'h1);
		rg(1, OFS_TIMING, TIMING_RST, q);
		rg(0, OFS_CQ_WORD, 0, q);
		chk(q, 32'h3C5A96E1);
		rg(1, OFS_DBG_MUX, 32'hFFFFFFFF, q);
		rg(0, OFS_DBG_MUX, 0, q);
		chk(q, 32'h00009F3F);
		rg(1, OFS_DBG_MUX, 0, q);
		rg(1, OFS_DBG_RB, 32'hFFFFFFFF, q);
		rg(0, 12'h200, 0, q);
		chk(q, 32'h0);
		rg(0, OFS_CQ_PTR, 0, q);
		chk(q, 32'h000005A5);
		$display("test regs done");
	endtask

	task automatic t_timing;
		int n;
		logic [31:0] q;
		bus(0, 0, n);
		chk(n, 17);
		bus(1, 0, n);
		chk(n, 6);
		bus(1, 1, n);
		chk(n, 2);
		rg(1, OFS_TIMING, 32'h00002019, q);
		bus(0, 0, n);
		chk(n, 8);
		bus(1, 0, n);
		chk(n, 4);
		$display("test timing done");
	endtask

	// both requesters at once; the policy names the first winner
	task automatic t_arb(input logic [1:0] pol, input logic hw);
		int n;
		logic [31:0] q;
		rg(1, OFS_TIMING, TIMING_RST | (32'(pol) << 8), q);
		@(posedge clk_sys) #2;
		host_req = '{1'b1, 1'b0, 1'b0, 12'h354, 32'h0};
		parser_req = '{1'b1, 1'b0, 1'b0, 12'h358, 32'h0};
		wait_done(n);
		chk(32'(host_done_q), 32'(hw));
		host_req.req = !host_done_q;
		parser_req.req = host_done_q;
		@(posedge clk_sys) #2;
		wait_done(n);
		chk(32'(parser_done_q), 32'(hw));
		{host_req.req, parser_req.req} = 2'b00;
		repeat (70) @(posedge clk_sys);
		$display("test arbitration done");
	endtask

	task automatic ap(input logic lg, input logic [23:0] a, input logic hit);
		int k;
		@(posedge clk_sys) #2;
		{ap_rd_req, ap_legacy, ap_addr} = {1'b1, lg, a};
		@(posedge clk_sys) #2;
		ap_rd_req = 1'b0;
		chk(32'(pc_rd_req_q), 32'(!hit));
		for (k = 0; k < 20 && ap_rd_valid_q !== 1'b1; k++)
			@(posedge clk_sys) #2;
		if (k == 20) begin
			n_mismatch++;
			conclude();
		end
		chk(32'(k == 0), 32'(hit));
		chk(ap_rd_data_q, {8'hC3, a});
	endtask

	task automatic t_reuse;
		logic [31:0] q;
		for (int lg = 0; lg < 2; lg++) begin
			ap(lg[0], 24'h001000 + 24'(lg), 0);
			ap(lg[0], 24'h001000 + 24'(lg), 1);
			rg(1, OFS_TIMING, TIMING_RST | (32'h01000000 << lg), q);
			ap(lg[0], 24'h001000 + 24'(lg), 0);
			rg(1, OFS_TIMING, TIMING_RST, q);
		end
		$display("test reuse done");
	endtask

	// connector enables set in the same write that drives the bus out
	task automatic t_debug;
		int b[2] = '{11, 17};
		logic [31:0] q;
		for (int i = 0; i < 2; i++) begin
			rg(1, OFS_DBG_MODE, (32'h1 << b[i]) | 32'hF, q);
			repeat (3) @(posedge clk_sys);
			#2;
			chk(32'(dbg_unit_sel_q), 32'h1 << (b[i] - 4));
			chk(32'(dbg_bus_q), 32'(unit_dbg[b[i] - 4]));
			chk(32'({dbg_bus_oe_q, dbg_in_low_en_q, dbg_in_high_en_q,
				quiescent_current_mode_q, pulls_off_q}), 32'h1F);
			rg(0, OFS_DBG_RB, 0, q);
			chk(q, 32'(unit_dbg[b[i] - 4]));
		end
		rg(1, OFS_DBG_MODE, 0, q);
		$display("test debug done");
	endtask

	task automatic t_clk;
		logic [31:0] w[3] = '{32'h0523, 32'h8523, 32'h8023};
		logic [31:0] q;
		for (int i = 0; i < 3; i++) begin
			rg(1, OFS_DBG_MUX, w[i], q);
			repeat (3) @(posedge clk_sys);
			#2;
			chk(32'(tst_clk_q), 32'(i == 0));
			chk(32'({dbg_mux_sel_q, dbg_bank_sel_q}), 32'h0E);
		end
		$display("test clock done");
	endtask

	task automatic t_ovr;
		int b[7] = '{0, 1, 6, 7, 8, 9, 12};
		logic [31:0] q;
		for (int i = 0; i < 7; i++) begin
			rg(1, OFS_HW_OVR, 32'h1 << b[i], q);
			@(posedge clk_sys) #2;
			chk(32'(hw_override_q), 32'h1 << b[i]);
			chk(32'({force_f2s_conventional_q, force_s2f_conventional_q,
				cmdproc_soft_reset_q, pixcache_soft_reset_q,
				pixengine_soft_reset_q, port_revision_select_q,
				sideband_bus_disable_q}), 32'h40 >> i);
		end
		$display("test overrides done");
	endtask

	// main sequence
	initial begin
		{resetn, reg_req, reg_wr, ap_rd_req, ap_wr, ap_legacy} = 6'h00;
		{reg_addr, reg_wdata, ap_addr} = '0;
		{host_req, parser_req} = '0;
		reg_be = 4'hF;
		tst_clk_src = 32'h00000020;
		cq_chk_ptr = 11'h5A5;
		cq_chk_word = 32'h3C5A96E1;
		for (int i = 0; i < NUM_SRC; i++)
			unit_dbg[i] = 11'h400 | 11'(i);
		repeat (8) @(posedge clk_sys);
		#2 resetn = 1'b1;
		t_regs();
		t_timing();
		t_arb(2'h1, 1'b1);
		t_arb(2'h2, 1'b0);
		t_arb(2'h0, 1'b0);
		t_reuse();
		t_debug();
		t_clk();
		t_ovr();
		conclude();
	end
endmodule
